// ### logic/ltimc_pkg.sv
// constants, register map and state types of the local time counter
// Notes on behaviour
// - configuration bit picks line or differential clock
// - works at 125, 156.25, 200, 250 MHz
// - programmed by period, not by frequency
// - every counter tick adds whole-ns period
// - femtosecond period error with direction bit held
// - accumulated error past 1 ns adds/removes ns
// - direction 0 removes the extra nanosecond
// - second counter, same sequence, programmable rollover
// - rollover mode 1 adds, 2 removes, else none
// - one-shot request moves counter exactly one ns
// - load enable copies load registers on edge
// - accuracy off: strobe synchronised before its edge is detected
// - save enable captures counter on strobe edge
// - auto-clear drops save enable after save
// - high accuracy compensates strobe offset for both
// - accuracy off: one tick of uncertainty
// - own counter per channel, shared strobe
package ltimc_pkg;

  // ****************************************
  // sizes and arithmetic constants
  // ****************************************
  localparam int          NCH        = 2;
  localparam int          ADDR_W     = 8;
  localparam int          CH_BIT     = 6;
  localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
  localparam logic [21:0] FS_PER_NS  = 22'h0F_4240;
  localparam logic [31:0] PLUS_ONE   = 32'h0000_0001;
  localparam logic [31:0] MINUS_ONE  = 32'hFFFF_FFFF;
  localparam logic [1:0]  AUTO_ADD   = 2'h1;
  localparam logic [1:0]  AUTO_SUB   = 2'h2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // ****************************************
  // register offsets inside a channel window
  // ****************************************
  localparam logic [5:0] OFF_CTRL     = 6'h00;
  localparam logic [5:0] OFF_PERIOD   = 6'h04;
  localparam logic [5:0] OFF_ERROR    = 6'h08;
  localparam logic [5:0] OFF_AUTO     = 6'h0C;
  localparam logic [5:0] OFF_LD_SEC_H = 6'h10;
  localparam logic [5:0] OFF_LD_SEC_L = 6'h14;
  localparam logic [5:0] OFF_LD_NS    = 6'h18;
  localparam logic [5:0] OFF_SV_SEC_H = 6'h1C;
  localparam logic [5:0] OFF_SV_SEC_L = 6'h20;
  localparam logic [5:0] OFF_SV_NS    = 6'h24;
  localparam logic [5:0] OFF_CUR_NS   = 6'h28;
  localparam logic [5:0] OFF_CUR_SEC  = 6'h2C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SEL_POS   = 0;
  localparam int CTRL_LOAD_POS  = 1;
  localparam int CTRL_SAVE_POS  = 2;
  localparam int CTRL_REQ_POS   = 3;
  localparam int CTRL_DIR_POS   = 4;
  localparam int CTRL_ACLR_POS  = 5;
  localparam int CTRL_HIACC_POS = 6;
  localparam int ERR_DIR_POS    = 31;
  localparam int AUTO_MODE_POS  = 30;

  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic [29:0] ns;
    logic [47:0] sec;
    logic [20:0] acc;
    logic [29:0] auto_ns;
    logic        auto_pend;
    logic        counter_clock_select;
    logic        time_load_enable;
    logic        time_save_enable;
    logic        one_ns_adjust_request;
    logic        one_ns_adjust_direction;
    logic        one_time_save_autoclear;
    logic        high_accuracy;
    logic [7:0]  period_whole_ns;
    logic [19:0] period_error_fs;
    logic        period_error_direction;
    logic [29:0] auto_correct_rollover_ns;
    logic [1:0]  auto_correct_mode;
    logic [15:0] load_seconds_high;
    logic [31:0] load_seconds_low;
    logic [29:0] load_nanoseconds;
    logic [15:0] saved_seconds_high;
    logic [31:0] saved_seconds_low;
    logic [29:0] saved_nanoseconds;
  } ltimc_chan_type;

  typedef struct packed {
    ltimc_chan_type [NCH-1:0] ch;
    logic                     line_prev;
    logic                     diff_prev;
    logic                     raw_prev;
    logic                     sync1;
    logic                     sync2;
    logic                     sync3;
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
    logic                     aw_hold;
    logic [ADDR_W-1:0]        aw_addr;
    logic                     w_hold;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
  } ltimc_state_type;

  localparam ltimc_state_type STATE_RESET = '0;

endpackage : ltimc_pkg

// ### logic/ltimc_top.sv
// local time counter channels with an AXI4-Lite register slave
`timescale 1ns/1ns
module ltimc_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [ltimc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [ltimc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  input  wire logic                         line_clock_in,
  input  wire logic                         timing_diff_clock_in,
  input  wire logic                         load_save_strobe_in
);

  // ****************************************
  // state and combinational terms
  // ****************************************
  ltimc_pkg::ltimc_state_type q;
  ltimc_pkg::ltimc_state_type n;

  logic                      line_tick;
  logic                      diff_tick;
  logic                      sync_edge;
  logic                      raw_edge;
  logic                      do_write;
  logic [ltimc_pkg::NCH-1:0] tick_c;
  logic [ltimc_pkg::NCH-1:0] edge_c;
  logic [ltimc_pkg::NCH-1:0] fs_wrap_c;
  logic [ltimc_pkg::NCH-1:0] roll_c;
  logic [21:0]               acc_sum_c  [ltimc_pkg::NCH];
  logic [31:0]               base_c     [ltimc_pkg::NCH];
  logic [31:0]               step_c     [ltimc_pkg::NCH];
  logic [31:0]               ns_sum_c   [ltimc_pkg::NCH];
  logic [31:0]               auto_sum_c [ltimc_pkg::NCH];
  logic [32:0]               rd_word;
  logic [32:0]               wr_old;
  logic [31:0]               wr_new;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // top bit says the offset is mapped
  function automatic logic [32:0] reg_read(input ltimc_pkg::ltimc_chan_type c, input logic [5:0] off);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (off)
      ltimc_pkg::OFF_CTRL: begin
        r[ltimc_pkg::CTRL_SEL_POS]   = c.counter_clock_select;
        r[ltimc_pkg::CTRL_LOAD_POS]  = c.time_load_enable;
        r[ltimc_pkg::CTRL_SAVE_POS]  = c.time_save_enable;
        r[ltimc_pkg::CTRL_REQ_POS]   = c.one_ns_adjust_request;
        r[ltimc_pkg::CTRL_DIR_POS]   = c.one_ns_adjust_direction;
        r[ltimc_pkg::CTRL_ACLR_POS]  = c.one_time_save_autoclear;
        r[ltimc_pkg::CTRL_HIACC_POS] = c.high_accuracy;
      end
      ltimc_pkg::OFF_PERIOD: r[7:0] = c.period_whole_ns;
      ltimc_pkg::OFF_ERROR: begin
        r[19:0]                    = c.period_error_fs;
        r[ltimc_pkg::ERR_DIR_POS]  = c.period_error_direction;
      end
      ltimc_pkg::OFF_AUTO: begin
        r[29:0]                                       = c.auto_correct_rollover_ns;
        r[ltimc_pkg::AUTO_MODE_POS +: 2]              = c.auto_correct_mode;
      end
      ltimc_pkg::OFF_LD_SEC_H: r[15:0] = c.load_seconds_high;
      ltimc_pkg::OFF_LD_SEC_L: r[31:0] = c.load_seconds_low;
      ltimc_pkg::OFF_LD_NS:    r[29:0] = c.load_nanoseconds;
      ltimc_pkg::OFF_SV_SEC_H: r[15:0] = c.saved_seconds_high;
      ltimc_pkg::OFF_SV_SEC_L: r[31:0] = c.saved_seconds_low;
      ltimc_pkg::OFF_SV_NS:    r[29:0] = c.saved_nanoseconds;
      ltimc_pkg::OFF_CUR_NS:   r[29:0] = c.ns;
      ltimc_pkg::OFF_CUR_SEC:  r[31:0] = c.sec[31:0];
      default:                 r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction : reg_read

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    // clock sources arrive as synchronous levels; a rising edge is one counter tick
    n.line_prev = line_clock_in;
    n.diff_prev = timing_diff_clock_in;
    line_tick   = line_clock_in & ~q.line_prev;
    diff_tick   = timing_diff_clock_in & ~q.diff_prev;
    // two-stage synchroniser, edge taken after the second stage
    n.sync1     = load_save_strobe_in;
    n.sync2     = q.sync1;
    n.sync3     = q.sync2;
    sync_edge   = q.sync2 & ~q.sync3;
    // direct path skips the synchroniser latency
    n.raw_prev  = load_save_strobe_in;
    raw_edge    = load_save_strobe_in & ~q.raw_prev;

    // register bus, address and data taken in either order
    if (q.awready && s_axi_awvalid) begin
      n.aw_hold = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      n.w_hold = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    do_write = q.aw_hold & q.w_hold & ~q.bvalid;
    wr_old   = reg_read(q.ch[q.aw_addr[ltimc_pkg::CH_BIT]], {q.aw_addr[5:2], 2'b00});
    wr_new   = merge_bytes(wr_old[31:0], q.wdata, q.wstrb);
    if (do_write) begin
      n.aw_hold = 1'b0;
      n.w_hold  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = (wr_old[32] && !q.aw_addr[7]) ? ltimc_pkg::RESP_OKAY : ltimc_pkg::RESP_SLV;
    end
    n.awready = ~n.aw_hold;
    n.wready  = ~n.w_hold;

    rd_word = reg_read(q.ch[s_axi_araddr[ltimc_pkg::CH_BIT]], {s_axi_araddr[5:2], 2'b00});
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = (rd_word[32] && !s_axi_araddr[7]) ? rd_word[31:0] : 32'h0000_0000;
      n.rresp  = (rd_word[32] && !s_axi_araddr[7]) ? ltimc_pkg::RESP_OKAY : ltimc_pkg::RESP_SLV;
    end
    n.arready = ~n.rvalid;

    // each channel keeps its own counter off the shared strobe
    for (int c = 0; c < ltimc_pkg::NCH; c++) begin
      tick_c[c] = q.ch[c].counter_clock_select ? diff_tick : line_tick;
      edge_c[c] = q.ch[c].high_accuracy ? raw_edge : sync_edge;
      // period programmed in ns so any rate in range works
      acc_sum_c[c] = {1'b0, q.ch[c].acc} + {2'b00, q.ch[c].period_error_fs};
      fs_wrap_c[c] = acc_sum_c[c] >= ltimc_pkg::FS_PER_NS;
      base_c[c]    = {24'h00_0000, q.ch[c].period_whole_ns};
      if (fs_wrap_c[c]) begin
        base_c[c] = base_c[c] + (q.ch[c].period_error_direction ? ltimc_pkg::PLUS_ONE
                                                                : ltimc_pkg::MINUS_ONE);
      end
      // correction counter follows the same sequence
      auto_sum_c[c] = {2'b00, q.ch[c].auto_ns} + base_c[c];
      roll_c[c]     = (q.ch[c].auto_correct_rollover_ns != 30'h0000_0000) &&
                      (auto_sum_c[c] >= {2'b00, q.ch[c].auto_correct_rollover_ns});
      step_c[c]     = base_c[c];
      // mode is read again here, so switching to a no-correction code drops a queued correction
      if (q.ch[c].auto_pend && q.ch[c].auto_correct_mode == ltimc_pkg::AUTO_ADD) begin
        step_c[c] = step_c[c] + ltimc_pkg::PLUS_ONE;
      end else if (q.ch[c].auto_pend && q.ch[c].auto_correct_mode == ltimc_pkg::AUTO_SUB) begin
        step_c[c] = step_c[c] + ltimc_pkg::MINUS_ONE;
      end
      if (q.ch[c].one_ns_adjust_request) begin
        step_c[c] = step_c[c] + (q.ch[c].one_ns_adjust_direction ? ltimc_pkg::PLUS_ONE
                                                                 : ltimc_pkg::MINUS_ONE);
      end
      ns_sum_c[c] = {2'b00, q.ch[c].ns} + step_c[c];
      if (tick_c[c]) begin
        // a negative sum borrows a second, an overflow carries one
        if (ns_sum_c[c][31]) begin
          n.ch[c].ns  = 30'(ns_sum_c[c] + ltimc_pkg::NS_PER_SEC);
          n.ch[c].sec = q.ch[c].sec - 48'h0000_0000_0001;
        end else if (ns_sum_c[c] >= ltimc_pkg::NS_PER_SEC) begin
          n.ch[c].ns  = 30'(ns_sum_c[c] - ltimc_pkg::NS_PER_SEC);
          n.ch[c].sec = q.ch[c].sec + 48'h0000_0000_0001;
        end else begin
          n.ch[c].ns  = ns_sum_c[c][29:0];
        end
        n.ch[c].acc       = fs_wrap_c[c] ? 21'(acc_sum_c[c] - ltimc_pkg::FS_PER_NS) : acc_sum_c[c][20:0];
        n.ch[c].auto_ns   = roll_c[c] ? 30'(auto_sum_c[c] - {2'b00, q.ch[c].auto_correct_rollover_ns})
                                      : auto_sum_c[c][29:0];
        // pending correction is used by the very next increment only
        n.ch[c].auto_pend = roll_c[c] && (q.ch[c].auto_correct_mode == ltimc_pkg::AUTO_ADD ||
                                          q.ch[c].auto_correct_mode == ltimc_pkg::AUTO_SUB);
        n.ch[c].one_ns_adjust_request = 1'b0;
      end
      // save sees the value before a same-edge load replaces it
      if (edge_c[c] && q.ch[c].time_save_enable) begin
        n.ch[c].saved_seconds_high = q.ch[c].sec[47:32];
        n.ch[c].saved_seconds_low  = q.ch[c].sec[31:0];
        n.ch[c].saved_nanoseconds  = q.ch[c].ns;
        if (q.ch[c].one_time_save_autoclear) begin
          n.ch[c].time_save_enable = 1'b0;
        end
      end
      // software is trusted to stage the load before raising the strobe
      if (edge_c[c] && q.ch[c].time_load_enable) begin
        n.ch[c].sec = {q.ch[c].load_seconds_high, q.ch[c].load_seconds_low};
        n.ch[c].ns  = q.ch[c].load_nanoseconds;
      end
      if (do_write && !q.aw_addr[7] && (q.aw_addr[ltimc_pkg::CH_BIT] == 1'(c))) begin
        case ({q.aw_addr[5:2], 2'b00})
          ltimc_pkg::OFF_CTRL: begin
            n.ch[c].counter_clock_select    = wr_new[ltimc_pkg::CTRL_SEL_POS];
            n.ch[c].time_load_enable        = wr_new[ltimc_pkg::CTRL_LOAD_POS];
            n.ch[c].time_save_enable        = wr_new[ltimc_pkg::CTRL_SAVE_POS];
            // writing one queues a request, writing zero never cancels one
            n.ch[c].one_ns_adjust_request   = n.ch[c].one_ns_adjust_request |
                                              (s_axi_wdata_sel(q.wdata, q.wstrb));
            n.ch[c].one_ns_adjust_direction = wr_new[ltimc_pkg::CTRL_DIR_POS];
            n.ch[c].one_time_save_autoclear = wr_new[ltimc_pkg::CTRL_ACLR_POS];
            n.ch[c].high_accuracy           = wr_new[ltimc_pkg::CTRL_HIACC_POS];
          end
          ltimc_pkg::OFF_PERIOD: n.ch[c].period_whole_ns = wr_new[7:0];
          ltimc_pkg::OFF_ERROR: begin
            n.ch[c].period_error_fs        = wr_new[19:0];
            n.ch[c].period_error_direction = wr_new[ltimc_pkg::ERR_DIR_POS];
          end
          ltimc_pkg::OFF_AUTO: begin
            n.ch[c].auto_correct_rollover_ns = wr_new[29:0];
            n.ch[c].auto_correct_mode        = wr_new[ltimc_pkg::AUTO_MODE_POS +: 2];
          end
          ltimc_pkg::OFF_LD_SEC_H: n.ch[c].load_seconds_high = wr_new[15:0];
          ltimc_pkg::OFF_LD_SEC_L: n.ch[c].load_seconds_low  = wr_new[31:0];
          ltimc_pkg::OFF_LD_NS:    n.ch[c].load_nanoseconds  = wr_new[29:0];
          default: begin
          end
        endcase
      end
    end
  end

  // request bit only counts when its byte lane is strobed
  function automatic logic s_axi_wdata_sel(input logic [31:0] d, input logic [3:0] s);
    return d[ltimc_pkg::CTRL_REQ_POS] & s[0];
  endfunction : s_axi_wdata_sel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ltimc_pkg::STATE_RESET;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // ****************************************
  // checks
  // ****************************************
  default clocking chk_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  clk_select_a: assert property (
    q.ch[0].counter_clock_select && line_tick && !diff_tick |-> !tick_c[0])
    else $error("line clock ticked while differential source selected");

  period_add_a: assert property (
    tick_c[0] && !fs_wrap_c[0] && !q.ch[0].auto_pend && !q.ch[0].one_ns_adjust_request && !edge_c[0] &&
    !do_write && q.ch[0].ns < 30'h3B9A_C000
    |=> q.ch[0].ns == $past(q.ch[0].ns) + 30'($past(q.ch[0].period_whole_ns)))
    else $error("plain tick did not add the period");

  fs_carry_a: assert property (
    tick_c[0] && fs_wrap_c[0] && !edge_c[0]
    |=> {1'b0, q.ch[0].acc} == 22'($past(acc_sum_c[0]) - 22'h0F_4240))
    else $error("error accumulator did not drop one nanosecond");

  fs_subtract_a: assert property (
    tick_c[0] && fs_wrap_c[0] && !q.ch[0].period_error_direction && !q.ch[0].auto_pend &&
    !q.ch[0].one_ns_adjust_request && !edge_c[0] && !do_write &&
    q.ch[0].ns != 30'h0000_0000 && q.ch[0].ns < 30'h3B9A_C000
    |=> q.ch[0].ns == $past(q.ch[0].ns) + 30'($past(q.ch[0].period_whole_ns)) - 30'h0000_0001)
    else $error("direction zero did not remove a nanosecond");

  auto_none_a: assert property (
    tick_c[0] && roll_c[0] && (q.ch[0].auto_correct_mode == 2'h0 || q.ch[0].auto_correct_mode == 2'h3)
    |=> !q.ch[0].auto_pend)
    else $error("correction pending in a no-correction mode");

  auto_add_a: assert property (
    tick_c[0] && roll_c[0] && q.ch[0].auto_correct_mode == 2'h1 |=> q.ch[0].auto_pend)
    else $error("rollover did not queue a correction");

  oneshot_clear_a: assert property (
    tick_c[0] && q.ch[0].one_ns_adjust_request && !do_write |=> !q.ch[0].one_ns_adjust_request)
    else $error("one-shot request not consumed");

  sync_delay_a: assert property (
    !q.ch[0].high_accuracy && edge_c[0]
    |-> $past(load_save_strobe_in, 2) && !$past(load_save_strobe_in, 3))
    else $error("edge seen without passing the synchroniser");

  load_copy_a: assert property (
    edge_c[1] && q.ch[1].time_load_enable
    |=> q.ch[1].ns == $past(q.ch[1].load_nanoseconds) && q.ch[1].sec[31:0] == $past(q.ch[1].load_seconds_low))
    else $error("strobe did not load the channel");

  save_capture_a: assert property (
    edge_c[0] && q.ch[0].time_save_enable |=> q.ch[0].saved_nanoseconds == $past(q.ch[0].ns))
    else $error("strobe did not save the time");

  save_clear_a: assert property (
    edge_c[0] && q.ch[0].time_save_enable && q.ch[0].one_time_save_autoclear && !do_write
    |=> !q.ch[0].time_save_enable)
    else $error("one-time save enable not cleared");

  ns_range_a: assert property (
    q.ch[0].ns < 30'h3B9A_CA00 && q.ch[0].load_nanoseconds < 30'h3B9A_CA00 |=> q.ch[0].ns < 30'h3B9A_CA00)
    else $error("nanoseconds left their range");

endmodule : ltimc_top

// ### test/ltimc_partner.sv
// far-side timing logic: counter clock bursts and the shared load/save strobe
`timescale 1ns/1ns
module ltimc_partner (
  input  wire logic aclk,
  output logic      line_clock_in,
  output logic      timing_diff_clock_in,
  output logic      load_save_strobe_in
);
  initial begin
    line_clock_in = 1'b0;
    timing_diff_clock_in = 1'b0;
    load_save_strobe_in = 1'b0;
  end
  // clocks stand still low between bursts so reads see a frozen counter
  task automatic tick(input bit diff, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (diff) timing_diff_clock_in <= 1'b1;
      else line_clock_in <= 1'b1;
      @(posedge aclk);
      line_clock_in <= 1'b0;
      timing_diff_clock_in <= 1'b0;
    end
  endtask : tick
  // raised only once the bench has written load values and enables
  task automatic strobe();
    @(posedge aclk);
    load_save_strobe_in <= 1'b1;
    repeat (5) @(posedge aclk);
    load_save_strobe_in <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : strobe
endmodule : ltimc_partner

// ### test/local_time_counter_test.sv
// self-checking bench for the local time counter
`timescale 1ns/1ns
module local_time_counter_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic   awready, wready, bvalid, arready, rvalid, lclk, dclk, stb;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          err_count, samples_checked, pend, os, edir, amode;
  longint      m_ns, m_sec, acc, aut, per, efs, roll, st;
  localparam logic [1:0] OK = ltimc_pkg::RESP_OKAY;
  ltimc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .line_clock_in(lclk),
    .timing_diff_clock_in(dclk), .load_save_strobe_in(stb));
  ltimc_partner u_p (.aclk(aclk), .line_clock_in(lclk), .timing_diff_clock_in(dclk), .load_save_strobe_in(stb));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic close_out();
    $display("compares %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin err_count++; close_out(); end
    chk({30'h0, bresp}, {30'h0, a[7] ? ltimc_pkg::RESP_SLV : OK});
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin err_count++; close_out(); end
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rdchk
  // integer model of one channel; a rollover queues a correction only in an active mode,
  // and the correction follows the mode in force when it is applied
  task automatic mtick(input int n);
    repeat (n) begin
      st = per;
      acc += efs;
      if (acc >= 64'h000F_4240) begin acc -= 64'h000F_4240; st += edir ? 1 : -1; end
      m_ns += st + os + ((pend == 0) ? 0 : (amode == 1) ? 1 : (amode == 2) ? -1 : 0);
      pend = 0; os = 0;
      aut += st;
      if (roll != 0 && aut >= roll) begin aut -= roll; pend = (amode == 1 || amode == 2); end
      if (m_ns < 0) begin m_ns += ltimc_pkg::NS_PER_SEC; m_sec--; end
      if (m_ns >= ltimc_pkg::NS_PER_SEC) begin m_ns -= ltimc_pkg::NS_PER_SEC; m_sec++; end
    end
  endtask : mtick
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
    err_count = 0; samples_checked = 0; pend = 0; os = 0; acc = 0; aut = 0; roll = 0; amode = 0;
    void'($urandom(87));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h80, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h0, OK);
    rdchk(8'h80, 32'h0, ltimc_pkg::RESP_SLV);
    $display("reset test done");
    m_ns = ltimc_pkg::NS_PER_SEC - 40 + ($urandom % 16);
    m_sec = 64'h1_0000_0000 + ($urandom % 256);
    wr(8'h10, 32'h1); wr(8'h14, 32'(m_sec)); wr(8'h18, 32'(m_ns));
    wr(8'h58, 32'h1234); wr(8'h40, 32'h2); wr(8'h00, 32'h2);
    u_p.strobe();
    rdchk(8'h28, 32'(m_ns), OK);
    rdchk(8'h68, 32'h1234, OK);
    $display("load test done");
    per = 6; efs = 100000; edir = 0;
    wr(8'h00, 32'h0); wr(8'h04, 32'h6); wr(8'h08, 32'h0001_86A0);
    u_p.tick(0, 25); mtick(25);
    rdchk(8'h28, 32'(m_ns), OK);
    rdchk(8'h2C, 32'(m_sec), OK);
    edir = 1;
    wr(8'h08, 32'h8001_86A0); wr(8'h00, 32'h1);
    u_p.tick(0, 3); u_p.tick(1, 12); mtick(12);
    rdchk(8'h28, 32'(m_ns), OK);
    $display("period test done");
    for (int d = 0; d < 2; d++) begin
      wr(8'h00, d ? 32'h19 : 32'h9); os = d ? 1 : -1;
      u_p.tick(1, 1); mtick(1);
      rdchk(8'h28, 32'(m_ns), OK);
    end
    roll = 30;
    for (int m = 0; m < 4; m++) begin
      amode = m; wr(8'h0C, {2'(m), 30'h1E});
      u_p.tick(1, 10); mtick(10);
      rdchk(8'h28, 32'(m_ns), OK);
    end
    $display("adjust test done");
    wr(8'h00, 32'h25);
    u_p.strobe();
    rdchk(8'h1C, 32'(m_sec >> 32), OK);
    rdchk(8'h20, 32'(m_sec), OK);
    rdchk(8'h24, 32'(m_ns), OK);
    rdchk(8'h00, 32'h21, OK);
    $display("save test done");
    wr(8'h18, 32'h55);
    wr(8'h00, 32'h42);
    u_p.strobe();
    rdchk(8'h28, 32'h55, OK);
    $display("accuracy test done");
    close_out();
  end
endmodule : local_time_counter_test
